// ==== pcs_pkg.sv ====
/*
 * Constants and types shared by the program counter and return stack.
 * Assumes a single core clock and an 8-bit software register port.
 */
`default_nettype none

package pcs_pkg;

	localparam int unsigned PC_W = 21;
	localparam int unsigned PTR_W = 5;
	localparam int unsigned STACK_DEPTH = 31;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	// software register offsets
	localparam logic [3:0] OFS_LOW = 4'h0;
	localparam logic [3:0] OFS_HLAT = 4'h1;
	localparam logic [3:0] OFS_ULAT = 4'h2;
	localparam logic [3:0] OFS_TOPL = 4'h3;
	localparam logic [3:0] OFS_TOPH = 4'h4;
	localparam logic [3:0] OFS_TOPU = 4'h5;
	localparam logic [3:0] OFS_SPTR = 4'h6;

	// stack pointer register fields
	localparam int unsigned SPTR_FULL_BIT = 7;
	localparam int unsigned SPTR_OVF_BIT = 6;
	localparam int unsigned SPTR_UNF_BIT = 5;

	// reset values and fixed addresses
	localparam logic [20:0] PC_RST = 21'h000000;
	localparam logic [20:0] PC_STEP = 21'h000002;
	localparam logic [20:0] VEC_HIGH = 21'h000008;
	localparam logic [20:0] VEC_LOW = 21'h000018;
	localparam logic [4:0] PTR_RST = 5'h00;
	localparam logic [4:0] PTR_MAX = 5'h1f;
	localparam logic [7:0] HLAT_RST = 8'h00;
	localparam logic [4:0] ULAT_RST = 5'h00;

	// byte masks of a stack entry
	localparam logic [20:0] MASK_LOW = 21'h0000ff;
	localparam logic [20:0] MASK_HIGH = 21'h00ff00;
	localparam logic [20:0] MASK_UPPER = 21'h1f0000;

	typedef enum logic [6:0] {
		OP_NONE = 7'b0000001,
		OP_STEP = 7'b0000010,
		OP_SWPC = 7'b0000100,
		OP_JUMP = 7'b0001000,
		OP_CALL = 7'b0010000,
		OP_RET = 7'b0100000,
		OP_INT = 7'b1000000
	} pcs_op_e;

endpackage

`default_nettype wire

// ==== pcs_stack_mem.sv ====
/*
 * Return stack storage: entries held in flip-flops, one masked write port
 * and one combinational read port at the stack pointer; a push writes the slot one above it.
 * Assumes pointer value zero has no entry behind it and reads as zero.
 */
`default_nettype none

module pcs_stack_mem #(
	parameter int unsigned DEPTH = 31,
	parameter int unsigned WIDTH = 21,
	parameter int unsigned IDX_W = 5
) (
	input wire logic ref_clk_i,
	input wire logic wr_en_i,
	input wire logic [IDX_W-1:0] wr_idx_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic [WIDTH-1:0] wr_mask_i,
	input wire logic [IDX_W-1:0] rd_idx_i,
	output logic [WIDTH-1:0] rd_data_o
);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [IDX_W-1:0] wr_slot;
	logic [IDX_W-1:0] rd_slot;

	assign wr_slot = IDX_W'(wr_idx_i - 1'b1);
	assign rd_slot = IDX_W'(rd_idx_i - 1'b1);

	////////////////////////////////////////////////////////////////////////
	// masked write, index zero has no storage
	always_comb begin
		mem_d = mem_q;
		if (wr_en_i && wr_idx_i != '0) begin
			mem_d[wr_slot] = (mem_q[wr_slot] & ~wr_mask_i) |
				(wr_data_i & wr_mask_i);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		mem_q <= mem_d;
	end

	////////////////////////////////////////////////////////////////////////
	// addressed entry
	always_comb begin
		if (rd_idx_i == '0) begin
			rd_data_o = '0;
		end else begin
			rd_data_o = mem_q[rd_slot];
		end
	end

endmodule

`default_nettype wire

// ==== pcs_core.sv ====
/*
 * Program counter with high/upper latches and a hardware return stack.
 * Assumes the core raises at most the operation strobes it means in a
 * cycle and that pushes already see the counter past the calling word.
 */
// The register addresses and strobed register access were decided locally.
`default_nettype none

module pcs_core
	import pcs_pkg::*;
#(
	parameter int unsigned DEPTH = STACK_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic advance_i,
	input wire logic jump_i,
	input wire logic [PC_W-1:0] jump_addr_i,
	input wire logic call_i,
	input wire logic [PC_W-1:0] call_addr_i,
	input wire logic ret_i,
	input wire logic int_ack_i,
	input wire logic int_high_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rd_data_o,
	output logic [PC_W-1:0] fetch_addr_o,
	output logic [PTR_W-1:0] stack_ptr_o,
	output logic stack_full_o,
	output logic stack_overflow_o,
	output logic stack_underflow_o
);

	pcs_op_e op;
	logic [PC_W-1:0] pc_q, pc_d;
	logic [7:0] hlat_q, hlat_d;
	logic [4:0] ulat_q, ulat_d;
	logic [PTR_W-1:0] ptr_q, ptr_d;
	logic full_q, full_d;
	logic ovf_q, ovf_d;
	logic unf_q, unf_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic ovf_set, unf_set;
	logic stack_op;
	logic sptr_wr;
	logic mem_we;
	logic [PTR_W-1:0] mem_idx;
	logic [PC_W-1:0] mem_wdata;
	logic [PC_W-1:0] mem_wmask;
	logic [PC_W-1:0] top_entry;
	logic [7:0] pc_mid;
	logic [4:0] pc_top;

	assign pc_mid = pc_q[15:8];
	assign pc_top = pc_q[20:16];

	////////////////////////////////////////////////////////////////////////
	// operation select, interrupt, return, call and jump win over software; a software low-byte write wins over a step
	always_comb begin
		if (int_ack_i) begin
			op = OP_INT;
		end else if (ret_i) begin
			op = OP_RET;
		end else if (call_i) begin
			op = OP_CALL;
		end else if (jump_i) begin
			op = OP_JUMP;
		end else if (wr_i && addr_i == OFS_LOW) begin
			op = OP_SWPC;
		end else if (advance_i) begin
			op = OP_STEP;
		end else begin
			op = OP_NONE;
		end
	end

	// software stack and pointer writes yield to a push or pop in the same cycle
	assign stack_op = (op == OP_INT) || (op == OP_CALL) ||
		(op == OP_RET);
	assign sptr_wr = wr_i && addr_i == OFS_SPTR && !stack_op;

	////////////////////////////////////////////////////////////////////////
	// counter and stack pointer next state
	always_comb begin
		pc_d = pc_q;
		ptr_d = ptr_q;
		ovf_set = 1'b0;
		unf_set = 1'b0;
		mem_we = 1'b0;
		mem_idx = ptr_q;
		mem_wdata = pc_q;
		mem_wmask = '1;
		unique case (op)
			OP_INT: begin
				if (ptr_q == PTR_MAX) begin
					ovf_set = 1'b1;
				end else begin
					ptr_d = PTR_W'(ptr_q + 1'b1);
					mem_we = 1'b1;
					mem_idx = PTR_W'(ptr_q + 1'b1);
				end
				pc_d = int_high_i ? VEC_HIGH : VEC_LOW;
			end
			OP_CALL: begin
				if (ptr_q == PTR_MAX) begin
					ovf_set = 1'b1;
				end else begin
					ptr_d = PTR_W'(ptr_q + 1'b1);
					mem_we = 1'b1;
					mem_idx = PTR_W'(ptr_q + 1'b1);
				end
				pc_d = call_addr_i;
			end
			OP_RET: begin
				pc_d = top_entry;
				if (ptr_q == PTR_RST) begin
					unf_set = 1'b1;
				end else begin
					ptr_d = PTR_W'(ptr_q - 1'b1);
				end
			end
			OP_JUMP: begin
				pc_d = jump_addr_i;
			end
			OP_SWPC: begin
				pc_d = {ulat_q, hlat_q, wr_data_i};
			end
			OP_STEP: begin
				pc_d = PC_W'(pc_q + PC_STEP);
			end
			OP_NONE: begin
			end
		endcase
		if (!stack_op) begin
			if (sptr_wr) begin
				ptr_d = wr_data_i[PTR_W-1:0];
			end
			if (wr_i && ptr_q != PTR_RST) begin
				mem_wdata = {wr_data_i[4:0], wr_data_i, wr_data_i};
				if (addr_i == OFS_TOPL) begin
					mem_we = 1'b1;
					mem_wmask = MASK_LOW;
				end else if (addr_i == OFS_TOPH) begin
					mem_we = 1'b1;
					mem_wmask = MASK_HIGH;
				end else if (addr_i == OFS_TOPU) begin
					mem_we = 1'b1;
					mem_wmask = MASK_UPPER;
				end
			end
		end
		pc_d[0] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// status bits: set wins over a software clear
	always_comb begin
		ovf_d = ovf_q;
		unf_d = unf_q;
		if (sptr_wr && !wr_data_i[SPTR_OVF_BIT]) begin
			ovf_d = 1'b0;
		end
		if (sptr_wr && !wr_data_i[SPTR_UNF_BIT]) begin
			unf_d = 1'b0;
		end
		if (ovf_set) begin
			ovf_d = 1'b1;
		end
		if (unf_set) begin
			unf_d = 1'b1;
		end
		full_d = (ptr_d == PTR_MAX);
	end

	////////////////////////////////////////////////////////////////////////
	// latches: a low byte read copies, a latch write loads
	always_comb begin
		hlat_d = hlat_q;
		ulat_d = ulat_q;
		if (wr_i && addr_i == OFS_HLAT) begin
			hlat_d = wr_data_i;
		end
		if (wr_i && addr_i == OFS_ULAT) begin
			ulat_d = wr_data_i[4:0];
		end
		if (rd_i && addr_i == OFS_LOW) begin
			hlat_d = pc_mid;
			ulat_d = pc_top;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the read strobe
	always_comb begin
		rdata_d = '0;
		if (rd_i) begin
			unique case (addr_i)
				OFS_LOW: rdata_d = pc_q[7:0];
				OFS_HLAT: rdata_d = hlat_q;
				OFS_ULAT: rdata_d = {3'h0, ulat_q};
				OFS_TOPL: rdata_d = top_entry[7:0];
				OFS_TOPH: rdata_d = top_entry[15:8];
				OFS_TOPU: rdata_d = {3'h0, top_entry[20:16]};
				OFS_SPTR: rdata_d = {full_q, ovf_q, unf_q, ptr_q};
				default: rdata_d = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pc_q <= PC_RST;
			hlat_q <= HLAT_RST;
			ulat_q <= ULAT_RST;
			ptr_q <= PTR_RST;
			full_q <= 1'b0;
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			pc_q <= pc_d;
			hlat_q <= hlat_d;
			ulat_q <= ulat_d;
			ptr_q <= ptr_d;
			full_q <= full_d;
			ovf_q <= ovf_d;
			unf_q <= unf_d;
			rdata_q <= rdata_d;
		end
	end

	assign fetch_addr_o = pc_q;
	assign stack_ptr_o = ptr_q;
	assign stack_full_o = full_q;
	assign stack_overflow_o = ovf_q;
	assign stack_underflow_o = unf_q;
	assign rd_data_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// return stack storage
	pcs_stack_mem #(
		.DEPTH(DEPTH),
		.WIDTH(PC_W),
		.IDX_W(PTR_W)
	) u_mem (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(mem_we),
		.wr_idx_i(mem_idx),
		.wr_data_i(mem_wdata),
		.wr_mask_i(mem_wmask),
		.rd_idx_i(ptr_q),
		.rd_data_o(top_entry)
	);

	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_bit0;
		fetch_addr_o[0] == 1'b0;
	endproperty
	a_bit0: assert property (p_bit0) else $error("fetch bit0 set");

	property p_step;
		(op == OP_STEP) |=> pc_q == PC_W'($past(pc_q) + PC_STEP);
	endproperty
	a_step: assert property (p_step) else $error("step not two");

	property p_swpc;
		(op == OP_SWPC) |=> pc_q[20:8] == {$past(ulat_q), $past(hlat_q)}
			&& pc_q[7:1] == $past(wr_data_i[7:1]);
	endproperty
	a_swpc: assert property (p_swpc) else $error("latch load bad");

	property p_rdlat;
		(rd_i && addr_i == OFS_LOW) |=> hlat_q == $past(pc_mid)
			&& ulat_q == $past(pc_top);
	endproperty
	a_rdlat: assert property (p_rdlat) else $error("latch copy bad");

	property p_push;
		((op == OP_CALL || op == OP_INT) && ptr_q != PTR_MAX) |=>
			ptr_q == PTR_W'($past(ptr_q) + 1'b1) &&
			top_entry == $past(pc_q);
	endproperty
	a_push: assert property (p_push) else $error("push bad");

	property p_pop;
		(op == OP_RET && ptr_q != PTR_RST) |=>
			pc_q[20:1] == $past(top_entry[20:1]) &&
			ptr_q == PTR_W'($past(ptr_q) - 1'b1);
	endproperty
	a_pop: assert property (p_pop) else $error("pop bad");

	property p_vector;
		(op == OP_INT) |=> pc_q == ($past(int_high_i) ? VEC_HIGH : VEC_LOW);
	endproperty
	a_vector: assert property (p_vector) else $error("vector bad");

	property p_latch_kept;
		((op == OP_CALL || op == OP_RET) && !wr_i && !rd_i) |=>
			$stable(hlat_q) && $stable(ulat_q);
	endproperty
	a_latch_kept: assert property (p_latch_kept)
		else $error("latch moved");

	property p_ovf_sticky;
		(stack_overflow_o && !sptr_wr) |=> stack_overflow_o;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("ovf lost");

	property p_full;
		stack_full_o == (stack_ptr_o == PTR_MAX);
	endproperty
	a_full: assert property (p_full) else $error("full wrong");

	property p_reset;
		$rose(rst_n_i) |-> stack_ptr_o == PTR_RST;
	endproperty
	a_reset: assert property (p_reset) else $error("ptr not reset");

	c_push: cover property ((op == OP_CALL) ##[1:20] (op == OP_RET));
	c_ovf: cover property ($rose(stack_overflow_o));
	c_unf: cover property ($rose(stack_underflow_o));
	c_int_low: cover property (op == OP_INT && !int_high_i);

endmodule

`default_nettype wire

// ==== pcs_decode_model.sv ====
/*
 * Far-side model: the core decoder, turning one operation code a cycle
 * into the strobes and targets that pcs_core expects.
 * Assumes the bench changes the code just after a rising clock edge.
 */
`default_nettype none

module pcs_decode_model
	import pcs_pkg::*;
(
	input wire pcs_op_e op_i,
	input wire logic [PC_W-1:0] tgt_i,
	output logic advance_o,
	output logic jump_o,
	output logic call_o,
	output logic ret_o,
	output logic int_ack_o,
	output logic [PC_W-1:0] jump_addr_o,
	output logic [PC_W-1:0] call_addr_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// one operation a cycle; unused targets show a changing pattern
	always_comb begin
		advance_o = op_i == OP_STEP;
		jump_o = op_i == OP_JUMP;
		call_o = op_i == OP_CALL;
		ret_o = op_i == OP_RET;
		int_ack_o = op_i == OP_INT;
		jump_addr_o = jump_o ? tgt_i : ~tgt_i;
		call_addr_o = call_o ? tgt_i : ~tgt_i;
	end
endmodule

`default_nettype wire

// ==== pcs_core_tb.sv ====
/*
 * Self-checking bench for pcs_core: reference model, directed corners
 * and seeded random traffic. Assumes pcs_pkg and pcs_decode_model.
 */
`default_nettype none

module pcs_core_tb
	import pcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk = 0, rst_n = 0, hi = 0, wr = 0, rd = 0;
	logic adv, jmp, cal, ret, iak, fu, ov, un;
	logic [20:0] tgt = '0, ja, ca, fa, m_pc, stk [32];
	logic [3:0] ad = '0;
	logic [7:0] wd = '0, rdd, m_hl, m_rd;
	logic [4:0] spo, m_ul, m_sp;
	logic m_ov, m_un;
	pcs_op_e op = OP_NONE;
	pcs_op_e ops [6] = '{OP_NONE, OP_STEP, OP_JUMP, OP_CALL, OP_RET, OP_INT};
	int fails = 0, n_compared = 0, seed = 32'h77e5, cyc_n = 0;
	wire logic [15:0] st = {spo, fu, ov, un, rdd};

	pcs_decode_model pcs_decode_model_i (.op_i(op), .tgt_i(tgt),
		.advance_o(adv), .jump_o(jmp), .call_o(cal), .ret_o(ret),
		.int_ack_o(iak), .jump_addr_o(ja), .call_addr_o(ca));
	pcs_core pcs_core_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
		.advance_i(adv), .jump_i(jmp), .jump_addr_i(ja), .call_i(cal),
		.call_addr_i(ca), .ret_i(ret), .int_ack_i(iak), .int_high_i(hi),
		.addr_i(ad), .wr_data_i(wd), .wr_i(wr), .rd_i(rd),
		.rd_data_o(rdd), .fetch_addr_o(fa), .stack_ptr_o(spo),
		.stack_full_o(fu), .stack_overflow_o(ov), .stack_underflow_o(un));

	////////////////////////////////////////////////////////////////////
	initial forever #50 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [20:0] seen, input logic [20:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen,
				exp);
		end
	endtask

	function automatic void push(input logic [20:0] v);
		if (m_sp == PTR_MAX)
			m_ov = 1;
		else begin
			m_sp++;
			stk[m_sp] = v;
		end
	endfunction

	function automatic void put(input logic [20:0] m, input logic [7:0] d);
		if (m_sp != 0)
			stk[m_sp] = stk[m_sp] & ~m | {d[4:0], d, d} & m;
	endfunction

	function automatic logic [7:0] rdreg(input logic [3:0] a);
		logic [20:0] t;
		t = stk[m_sp];
		case (a)
			OFS_LOW: return m_pc[7:0];
			OFS_HLAT: return m_hl;
			OFS_ULAT: return {3'h0, m_ul};
			OFS_TOPL: return t[7:0];
			OFS_TOPH: return t[15:8];
			OFS_TOPU: return {3'h0, t[20:16]};
			OFS_SPTR: return {m_sp == PTR_MAX, m_ov, m_un, m_sp};
			default: return 8'h00;
		endcase
	endfunction

	task automatic do_reset(input int n);
		op <= OP_NONE;
		wr <= 0;
		rd <= 0;
		rst_n <= 0;
		repeat (n) @(posedge ref_clk);
		rst_n <= 1;
		@(posedge ref_clk);
		{m_pc, m_sp, m_hl, m_ul, m_ov, m_un, m_rd} = '0;
	endtask

	// one cycle: drive, take, update model, compare
	task automatic cyc(input pcs_op_e o, input logic [20:0] t,
		input logic h, input logic w, input logic r, input logic [3:0] a,
		input logic [7:0] d);
		logic [20:0] p;
		logic [15:0] e;
		op <= o;
		tgt <= t;
		hi <= h;
		wr <= w;
		rd <= r;
		ad <= a;
		wd <= d;
		@(posedge ref_clk);
		p = m_pc;
		m_rd = r ? rdreg(a) : 8'h00;
		case (o)
			OP_INT: begin
				push(m_pc);
				m_pc = h ? VEC_HIGH : VEC_LOW;
			end
			OP_RET: begin
				m_un |= m_sp == 0;
				m_pc = stk[m_sp] & ~21'h1;
				if (m_sp != 0) m_sp--;
			end
			OP_CALL: begin
				push(m_pc);
				m_pc = t & ~21'h1;
			end
			OP_JUMP: m_pc = t & ~21'h1;
			OP_STEP: m_pc += PC_STEP;
			default: ;
		endcase
		if (w) case (a)
			OFS_LOW: if (o != OP_JUMP) m_pc = {m_ul, m_hl, d[7:1], 1'b0};
			OFS_HLAT: m_hl = d;
			OFS_ULAT: m_ul = d[4:0];
			OFS_TOPL: put(MASK_LOW, d);
			OFS_TOPH: put(MASK_HIGH, d);
			OFS_TOPU: put(MASK_UPPER, d);
			OFS_SPTR: begin
				m_sp = d[4:0];
				m_ov &= d[6];
				m_un &= d[5];
			end
			default: ;
		endcase
		if (r && a == OFS_LOW) begin
			m_hl = p[15:8];
			m_ul = p[20:16];
		end
		e = {m_sp, m_sp == PTR_MAX, m_ov, m_un, m_rd};
		#1;
		check(fa, m_pc);
		check({5'h00, st}, {5'h00, e});
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		pcs_op_e o;
		logic [31:0] v;
		logic q;
		for (int i = 0; i < 32; i++) stk[i] = '0;
		do_reset(12);
		cyc(OP_NONE, '0, '0, '0, '1, OFS_SPTR, '0);
		cyc(OP_NONE, '0, '0, '1, '0, OFS_HLAT, 8'h12);
		cyc(OP_NONE, '0, '0, '1, '0, OFS_ULAT, 8'hff);
		cyc(OP_STEP, '0, '0, '1, '0, OFS_LOW, 8'h35);
		cyc(OP_STEP, '0, '0, '0, '1, OFS_LOW, '0);
		repeat (33) cyc(OP_CALL, 21'($random(seed)), '0, '0, '0, '0, '0);
		repeat (33) cyc(OP_RET, '0, '0, '0, '0, '0, '0);
		cyc(OP_NONE, '0, '0, '1, '0, OFS_SPTR, 8'h03);
		cyc(OP_NONE, '0, '0, '1, '0, OFS_TOPU, 8'hff);
		cyc(OP_NONE, '0, '0, '0, '1, OFS_TOPU, '0);
		cyc(OP_INT, '0, '1, '0, '0, '0, '0);
		cyc(OP_INT, '0, '0, '0, '0, '0, '0);
		repeat (2) cyc(OP_RET, '0, '0, '0, '0, '0, '0);
		repeat (3000) begin
			o = ops[$unsigned($random(seed)) % 6];
			v = $random(seed);
			q = o inside {OP_NONE, OP_STEP, OP_JUMP};
			cyc(o, v[20:0], v[21], q & v[22], q & ~v[22] & v[23], v[27:24],
				{v[31:25], 1'b0});
		end
		do_reset(2);
		cyc(OP_NONE, '0, '0, '0, '1, OFS_SPTR, '0);
		print_verdict();
	end
endmodule

`default_nettype wire
